// ===== hw/pgf_top.sv
// Function
// - Reserved filter and pull-up bits read zero.
// - Port C select bits 5:4 pick sample clock.
// - Port B select bits 3:2, same encoding.
// - Port A select picks its sample clock.
// - Keyboard select; bus dividers become low-power in stop.
// - Reset/irq select; code 0 unfiltered, stop fallback.
// - Drop glitches under one period, pass over two.
// - Low-power divider: oscillator clock over 2^code.
// - Slow divider: bus clock over 32 to 4096.
// - Fast divider: bus clock over 2 to 16.
// - Port A pull-up bits enable pin pull-ups.
// - Pull-up ignored on outputs and high-impedance pins.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pgf_top
  import pgf_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  low_power_osc_clock,
  input  wire logic                  stop_mode,
  input  wire logic [PA_W-1:0]       port_a_in,
  input  wire logic [PB_W-1:0]       port_b_in,
  input  wire logic [PC_W-1:0]       port_c_in,
  input  wire logic [KB_W-1:0]       keyboard_interrupt_inputs,
  input  wire logic                  reset_irq_in,
  output logic [PA_W-1:0]            port_a_filt,
  output logic [PB_W-1:0]            port_b_filt,
  output logic [PC_W-1:0]            port_c_filt,
  output logic [KB_W-1:0]            keyboard_filt,
  output logic                       reset_irq_filt,
  input  wire logic [PA_W-1:0]       port_a_is_output,
  input  wire logic [PA_W-1:0]       port_a_hiz,
  output logic [PA_W-1:0]            port_a_pullup_en
);

  function automatic logic [REG_N-1:0] reg_decode(input logic [IDX_W-1:0] idx);
    logic [REG_N-1:0] hit;
    hit             = '0;
    hit[SEL_FLT0]   = (idx == IDX_FLT0);
    hit[SEL_FLT2]   = (idx == IDX_FLT2);
    hit[SEL_FCLK]   = (idx == IDX_FCLKDIV);
    hit[SEL_PTAPE]  = (idx == IDX_PTAPE);
    hit[SEL_STATUS] = (idx == IDX_STATUS);
    return hit;
  endfunction

  function automatic logic [DIV_CNT_W-1:0] ones_mask(input logic [3:0] n);
    logic [DIV_CNT_W-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_CNT_W; i++) begin
      m[i] = (4'(i) < n);
    end
    return m;
  endfunction

  // For the keyboard and reset/irq groups the bus-divider codes fall back to the low-power divider during stop,
  // because the bus clock may not keep sampling while the core sleeps.
  function automatic logic grp_tick(input logic [1:0] sel, input logic fast, input logic slow,
                                    input logic lp, input logic stop_fb);
    logic t;
    case (sel)
      SEL_BUS:  t = 1'b1;
      SEL_FAST: t = stop_fb ? lp : fast;
      SEL_SLOW: t = stop_fb ? lp : slow;
      SEL_LP:   t = lp;
      default:  t = 1'b1;
    endcase
    return t;
  endfunction

  logic [7:0]            flt0_r;
  logic [7:0]            flt2_r;
  logic [7:0]            fclkdiv_r;
  logic [7:0]            ptape_r;
  logic [PA_W-1:0]       pullup_r;

  logic                  aw_hold_r;
  logic [IDX_W-1:0]      aw_idx_r;
  logic                  w_hold_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  rvalid_r;
  logic [31:0]           rdata_r;
  logic [1:0]            rresp_r;

  logic [DIV_CNT_W-1:0]  div_cnt_r;
  logic [LP_CNT_W-1:0]   lp_cnt_r;
  logic                  lpo_prev_r;

  // Write channel: address and data are taken independently and joined here.
  wire                   aw_take   = s_axi_awvalid && s_axi_awready;
  wire                   w_take    = s_axi_wvalid && s_axi_wready;
  wire                   aw_have   = aw_hold_r || aw_take;
  wire                   w_have    = w_hold_r || w_take;
  wire                   do_write  = aw_have && w_have && !bvalid_r;
  wire [IDX_W-1:0]       w_idx     = aw_hold_r ? aw_idx_r : s_axi_awaddr[AXI_ADDR_W-1:2];
  wire [31:0]            w_data    = w_hold_r ? wdata_r : s_axi_wdata;
  wire [3:0]             w_strb    = w_hold_r ? wstrb_r : s_axi_wstrb;
  wire [REG_N-1:0]       w_hit     = reg_decode(w_idx);
  wire                   w_lane0   = do_write && w_strb[0];
  wire                   w_mapped  = |w_hit;

  wire                   ar_take   = s_axi_arvalid && s_axi_arready;
  wire [REG_N-1:0]       r_hit     = reg_decode(s_axi_araddr[AXI_ADDR_W-1:2]);

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Divider settings and enable ticks.
  wire [2:0]             lp_code   = fclkdiv_r[LP_DIV_LSB +: 3];
  wire [2:0]             slow_code = fclkdiv_r[SLOW_DIV_LSB +: 3];
  wire [1:0]             fast_code = fclkdiv_r[FAST_DIV_LSB +: 2];
  wire [DIV_CNT_W-1:0]   fast_msk  = ones_mask(FAST_LOG2_BASE + {2'h0, fast_code});
  wire [DIV_CNT_W-1:0]   slow_msk  = ones_mask(SLOW_LOG2_BASE + {1'b0, slow_code});
  wire [DIV_CNT_W-1:0]   lp_msk    = ones_mask({1'b0, lp_code});
  wire                   fast_tick = &(div_cnt_r | ~fast_msk);
  wire                   slow_tick = &(div_cnt_r | ~slow_msk);
  wire                   lpo_rise  = low_power_osc_clock && !lpo_prev_r;
  wire                   lp_tick   = lpo_rise && (&(lp_cnt_r | ~lp_msk[LP_CNT_W-1:0]));

  wire [1:0]             pa_sel    = flt0_r[PA_SEL_LSB +: 2];
  wire [1:0]             pb_sel    = flt0_r[PB_SEL_LSB +: 2];
  wire [1:0]             pc_sel    = flt0_r[PC_SEL_LSB +: 2];
  wire [1:0]             kb_sel    = flt2_r[KB_SEL_LSB +: 2];
  wire [1:0]             ri_sel    = flt2_r[RI_SEL_LSB +: 2];

  wire                   pa_tick   = grp_tick(pa_sel, fast_tick, slow_tick, lp_tick, 1'b0);
  wire                   pb_tick   = grp_tick(pb_sel, fast_tick, slow_tick, lp_tick, 1'b0);
  wire                   pc_tick   = grp_tick(pc_sel, fast_tick, slow_tick, lp_tick, 1'b0);
  wire                   kb_tick   = grp_tick(kb_sel, fast_tick, slow_tick, lp_tick, stop_mode);
  wire                   ri_tick   = grp_tick(ri_sel, fast_tick, slow_tick, lp_tick, stop_mode);
  wire                   ri_bypass = (ri_sel == SEL_BUS);

  pgf_filt_if #(.N(FILT_N)) filt_bus ();

  assign filt_bus.raw    = {reset_irq_in, keyboard_interrupt_inputs, port_c_in, port_b_in, port_a_in};
  assign filt_bus.tick   = {ri_tick, {KB_W{kb_tick}}, {PC_W{pc_tick}}, {PB_W{pb_tick}}, {PA_W{pa_tick}}};
  assign filt_bus.bypass = {ri_bypass, {(FILT_N-1){1'b0}}};

  pgf_glitch_filter u_filter (
    .core_clk (core_clk),
    .rstn     (rstn),
    .fi       (filt_bus.filt_side)
  );

  assign port_a_filt    = filt_bus.filt[PA_LSB +: PA_W];
  assign port_b_filt    = filt_bus.filt[PB_LSB +: PB_W];
  assign port_c_filt    = filt_bus.filt[PC_LSB +: PC_W];
  assign keyboard_filt  = filt_bus.filt[KB_LSB +: KB_W];
  assign reset_irq_filt = filt_bus.filt[RI_BIT];

  // A pull-up only acts on a pin that is an input, never on a driven or floated one.
  wire [PA_W-1:0]        pullup_nxt = ptape_r[PA_W-1:0] & ~port_a_is_output & ~port_a_hiz;
  assign port_a_pullup_en = pullup_r;

  wire [7:0]             status_val = {stop_mode, reset_irq_filt, port_a_filt};
  wire [7:0]             rd_byte    = ({8{r_hit[SEL_FLT0]}}   & flt0_r)
                                    | ({8{r_hit[SEL_FLT2]}}   & flt2_r)
                                    | ({8{r_hit[SEL_FCLK]}}   & fclkdiv_r)
                                    | ({8{r_hit[SEL_PTAPE]}}  & ptape_r)
                                    | ({8{r_hit[SEL_STATUS]}} & status_val);

  // Masking at write time keeps reserved bits at zero in every register.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flt0_r    <= REG_RESET;
      flt2_r    <= REG_RESET;
      fclkdiv_r <= REG_RESET;
      ptape_r   <= REG_RESET;
    end else if (w_lane0) begin
      if (w_hit[SEL_FLT0]) begin
        flt0_r <= w_data[7:0] & FLT0_MASK;
      end
      if (w_hit[SEL_FLT2]) begin
        flt2_r <= w_data[7:0] & FLT2_MASK;
      end
      if (w_hit[SEL_FCLK]) begin
        fclkdiv_r <= w_data[7:0] & FCLKDIV_MASK;
      end
      if (w_hit[SEL_PTAPE]) begin
        ptape_r <= w_data[7:0] & PTAPE_MASK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      aw_idx_r  <= '0;
      w_hold_r  <= 1'b0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_idx_r <= s_axi_awaddr[AXI_ADDR_W-1:2];
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_hold_r <= aw_have && !do_write;
      w_hold_r  <= w_have && !do_write;
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h000000, rd_byte};
      rresp_r  <= (|r_hit) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_r  <= '0;
      lp_cnt_r   <= '0;
      lpo_prev_r <= 1'b0;
      pullup_r   <= '0;
    end else begin
      div_cnt_r  <= div_cnt_r + 1'b1;
      lpo_prev_r <= low_power_osc_clock;
      if (lpo_rise) begin
        lp_cnt_r <= lp_cnt_r + 1'b1;
      end
      pullup_r <= pullup_nxt;
    end
  end

endmodule

// ===== hw/pgf_pkg.sv
package pgf_pkg;

  // Register indices; each register takes one 32-bit word at byte address index*4.
  localparam int              AXI_ADDR_W   = 16;
  localparam int              IDX_W        = 14;
  localparam logic [IDX_W-1:0] IDX_FLT0    = 14'h30EC;
  localparam logic [IDX_W-1:0] IDX_FLT2    = 14'h30EE;
  localparam logic [IDX_W-1:0] IDX_FCLKDIV = 14'h30EF;
  localparam logic [IDX_W-1:0] IDX_PTAPE   = 14'h30F0;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 14'h30F8;

  // One-hot register select positions.
  localparam int REG_N      = 5;
  localparam int SEL_FLT0   = 0;
  localparam int SEL_FLT2   = 1;
  localparam int SEL_FCLK   = 2;
  localparam int SEL_PTAPE  = 3;
  localparam int SEL_STATUS = 4;

  // Writable bits; everything else reads as zero.
  localparam logic [7:0] FLT0_MASK    = 8'h3F;
  localparam logic [7:0] FLT2_MASK    = 8'h0F;
  localparam logic [7:0] FCLKDIV_MASK = 8'hFF;
  localparam logic [7:0] PTAPE_MASK   = 8'h2F;
  localparam logic [7:0] REG_RESET    = 8'h00;

  // Field positions.
  localparam int PC_SEL_LSB   = 4;
  localparam int PB_SEL_LSB   = 2;
  localparam int PA_SEL_LSB   = 0;
  localparam int KB_SEL_LSB   = 2;
  localparam int RI_SEL_LSB   = 0;
  localparam int LP_DIV_LSB   = 5;
  localparam int SLOW_DIV_LSB = 2;
  localparam int FAST_DIV_LSB = 0;

  // Filter clock selection codes.
  localparam logic [1:0] SEL_BUS  = 2'h0;
  localparam logic [1:0] SEL_FAST = 2'h1;
  localparam logic [1:0] SEL_SLOW = 2'h2;
  localparam logic [1:0] SEL_LP   = 2'h3;

  // Divider exponents: fast divides by 2^(code+1), slow by 2^(code+5), low-power by 2^code.
  localparam logic [3:0] FAST_LOG2_BASE = 4'h1;
  localparam logic [3:0] SLOW_LOG2_BASE = 4'h5;
  localparam int         DIV_CNT_W      = 12;
  localparam int         LP_CNT_W       = 7;

  // Pin groups packed into one filter vector.
  localparam int PA_W   = 6;
  localparam int PB_W   = 8;
  localparam int PC_W   = 4;
  localparam int KB_W   = 8;
  localparam int PA_LSB = 0;
  localparam int PB_LSB = 6;
  localparam int PC_LSB = 14;
  localparam int KB_LSB = 18;
  localparam int RI_BIT = 26;
  localparam int FILT_N = 27;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== hw/pgf_filt_if.sv
`timescale 1ns/100ps
interface pgf_filt_if #(
  parameter int N = 1
);
  logic [N-1:0] raw;
  logic [N-1:0] tick;
  logic [N-1:0] bypass;
  logic [N-1:0] filt;

  modport ctrl (output raw, output tick, output bypass, input filt);
  modport filt_side (input raw, input tick, input bypass, output filt);
endinterface

// ===== hw/pgf_glitch_filter.sv
`timescale 1ns/100ps
module pgf_glitch_filter (
  input wire logic  core_clk,
  input wire logic  rstn,
  pgf_filt_if.filt_side fi
);

  localparam int N = $bits(fi.raw);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic samp_r;
      logic filt_r;
      // Unless bypassed, a level counts only when two successive sample ticks agree, so a pulse
      // shorter than one tick period is never seen twice and is dropped.
      wire  agree = fi.tick[g] && (fi.raw[g] == samp_r);
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          samp_r <= 1'b0;
          filt_r <= 1'b0;
        end else begin
          if (fi.tick[g]) begin
            samp_r <= fi.raw[g];
          end
          if (fi.bypass[g]) begin
            filt_r <= fi.raw[g];
          end else if (agree) begin
            filt_r <= fi.raw[g];
          end
        end
      end
      assign fi.filt[g] = filt_r;
    end
  endgenerate

endmodule

// ===== tb/pgf_assertions.sv
`timescale 1ns/100ps
module pgf_assertions
  import pgf_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rstn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic [PC_W-1:0]       port_c_in,
  input wire logic [PC_W-1:0]       port_c_filt,
  input wire logic                  reset_irq_in,
  input wire logic                  reset_irq_filt,
  input wire logic [PA_W-1:0]       port_a_is_output,
  input wire logic [PA_W-1:0]       port_a_hiz,
  input wire logic [PA_W-1:0]       port_a_pullup_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Shadow copies assume the bench offers address and data together with all strobes set.
  logic [7:0] f0_r, f2_r, pe_r;
  wire logic  wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      f0_r <= 8'h00;
      f2_r <= 8'h00;
      pe_r <= 8'h00;
    end else if (wr_go) begin
      if (s_axi_awaddr == {IDX_FLT0, 2'h0}) f0_r <= s_axi_wdata[7:0];
      if (s_axi_awaddr == {IDX_FLT2, 2'h0}) f2_r <= s_axi_wdata[7:0];
      if (s_axi_awaddr == {IDX_PTAPE, 2'h0}) pe_r <= s_axi_wdata[7:0] & 8'h2F;
    end
  end

  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data has bits above the byte set");
  chk_write_answer: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_pullup_gate: assert property (
    port_a_pullup_en == $past(pe_r[PA_W-1:0] & ~port_a_is_output & ~port_a_hiz))
    else $error("pull-up enable wrong");
  chk_pullup_rsvd: assert property (port_a_pullup_en[4] == 1'b0)
    else $error("reserved pull-up bit active");
  chk_portc_pass: assert property (
    $past(f0_r[5:4]) == SEL_BUS && $past(f0_r[5:4], 2) == SEL_BUS &&
    port_c_in == $past(port_c_in) && port_c_in == $past(port_c_in, 2) |-> port_c_filt == port_c_in)
    else $error("steady port C level not passed");
  chk_irq_unfilt: assert property (
    $past(f2_r[1:0]) == 2'h0 |-> reset_irq_filt == $past(reset_irq_in))
    else $error("unfiltered reset pin not one cycle late");

  cover property (wr_go);
  cover property (s_axi_rvalid);
  cover property (port_c_filt != '0);
endmodule

bind pgf_top pgf_assertions u_chk (.*);

// ===== tb/pgf_pin_model.sv
`timescale 1ns/100ps
module pgf_pin_model
  import pgf_pkg::*;
#(
  parameter int LPO_HALF = 4
)
(
  input  wire logic            core_clk,
  output logic                 low_power_osc_clock,
  output logic [PA_W-1:0]      port_a_in,
  output logic [PB_W-1:0]      port_b_in,
  output logic [PC_W-1:0]      port_c_in,
  output logic [KB_W-1:0]      keyboard_interrupt_inputs,
  output logic                 reset_irq_in
);
  // Pin levels are set by the bench just after a clock edge; all start low.
  logic [FILT_N-1:0] lvl = '0;

  assign port_a_in                 = lvl[PA_LSB +: PA_W];
  assign port_b_in                 = lvl[PB_LSB +: PB_W];
  assign port_c_in                 = lvl[PC_LSB +: PC_W];
  assign keyboard_interrupt_inputs = lvl[KB_LSB +: KB_W];
  assign reset_irq_in              = lvl[RI_BIT];

  // The oscillator runs free, also in stop mode, so the fallback always has ticks.
  initial begin
    low_power_osc_clock = 1'b0;
    forever begin
      repeat (LPO_HALF) @(posedge core_clk);
      low_power_osc_clock <= ~low_power_osc_clock;
    end
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import pgf_pkg::*;
;
  logic                  core_clk, rstn, stop_mode, reset_irq_in, reset_irq_filt, low_power_osc_clock;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]            s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                  s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [PA_W-1:0]       port_a_in, port_a_filt, port_a_is_output, port_a_hiz, port_a_pullup_en;
  logic [PB_W-1:0]       port_b_in, port_b_filt;
  logic [PC_W-1:0]       port_c_in, port_c_filt;
  logic [KB_W-1:0]       keyboard_interrupt_inputs, keyboard_filt;
  wire logic [FILT_N-1:0] filt = {reset_irq_filt, keyboard_filt, port_c_filt, port_b_filt, port_a_filt};
  localparam logic [15:0] A_F0 = {IDX_FLT0, 2'h0};
  localparam logic [15:0] A_F2 = {IDX_FLT2, 2'h0};
  localparam logic [15:0] A_DIV = {IDX_FCLKDIV, 2'h0};
  localparam logic [15:0] A_PE = {IDX_PTAPE, 2'h0};
  logic [15:0]           ad [4] = '{A_F0, A_F2, A_DIV, A_PE};
  logic [7:0]            rb [4] = '{8'h3F, 8'h0F, 8'hFF, 8'h2F};
  int                    errors, num_checks;

  pgf_top DUT (.*);
  pgf_pin_model pins (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Handshakes are read at the falling edge, where they already stand as the next rising edge will see them.
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int         n;
    logic       aw_ok;
    logic       w_ok;
    logic       b_ok;
    logic [1:0] resp;
    n = 0;
    b_ok = 1'b0;
    resp = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge core_clk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      n++;
    end while (!b_ok && n < 50);
    if (!b_ok) errors++;
    chk(resp, r);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int          n;
    logic        ar_ok;
    logic        r_ok;
    logic [31:0] data;
    logic [1:0]  resp;
    n = 0;
    r_ok = 1'b0;
    data = '1;
    resp = 2'h3;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge core_clk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      n++;
    end while (!r_ok && n < 50);
    if (!r_ok) errors++;
    chk(data, {24'h0, d});
    chk(resp, r);
  endtask

  // Watches the filtered bit until the pin has long settled back low.
  task automatic pulse(input int b, input int len, input int span, input logic exp);
    logic seen;
    seen = 1'b0;
    pins.lvl[b] <= 1'b1;
    repeat (len) @(posedge core_clk) seen |= filt[b];
    pins.lvl[b] <= 1'b0;
    repeat (span) @(posedge core_clk) seen |= filt[b];
    chk(seen, exp);
  endtask

  task automatic tst(input int b, input int p);
    pulse(b, p - 1, 2 * p + 2, 1'b0);
    pulse(b, 3 * p, 3 * p, 1'b1);
  endtask

  initial begin
    #1000000;
    errors++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    stop_mode = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    port_a_is_output = '0;
    port_a_hiz = '0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      rd(ad[i], 8'h00);
      wr(ad[i], 8'hFF);
      rd(ad[i], rb[i]);
    end
    wr(16'hC3C4, 8'h55, RESP_SLVERR);
    rd(16'hC3C4, 8'h00, RESP_SLVERR);
    port_a_is_output <= 6'h02;
    port_a_hiz <= 6'h08;
    repeat (2) @(posedge core_clk);
    chk(port_a_pullup_en, 32'h25);
    wr(A_PE, 8'h10);
    repeat (2) @(posedge core_clk);
    chk(port_a_pullup_en, 32'h00);
    wr(A_F0, 8'h00);
    wr(A_F2, 8'h00);
    pulse(PB_LSB, 1, 4, 1'b0);
    pulse(PB_LSB, 3, 4, 1'b1);
    pulse(RI_BIT, 1, 3, 1'b1);
    wr(A_F0, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(A_DIV, 8'(c));
      tst(PA_LSB, 2 << c);
    end
    wr(A_F0, 8'h20);
    for (int c = 0; c < 8; c += 7) begin
      wr(A_DIV, 8'(c << 2));
      tst(PC_LSB, 32 << c);
    end
    wr(A_F0, 8'h0C);
    for (int c = 0; c < 4; c += 3) begin
      wr(A_DIV, 8'(c << 5));
      tst(PB_LSB, 8 << c);
    end
    wr(A_DIV, 8'h60);
    wr(A_F2, 8'h04);
    pulse(KB_LSB, 10, 12, 1'b1);
    stop_mode <= 1'b1;
    pulse(KB_LSB, 10, 140, 1'b0);
    wr(A_DIV, 8'h00);
    wr(A_F2, 8'h02);
    pulse(RI_BIT, 30, 30, 1'b1);
    stop_mode <= 1'b0;
    pulse(RI_BIT, 20, 70, 1'b0);
    print_verdict();
  end
endmodule
